// ==== spdrx_consts.svh ====
/*
 Register map, field positions, reset values and counts of the S/PDIF
 receiver lock and decode block. Assumes inclusion by bare name.
*/
`ifndef SPDRX_CONSTS_SVH
`define SPDRX_CONSTS_SVH

`define SPDRX_ADDR_LOCK     16'hf600
`define SPDRX_ADDR_CTRL     16'hf601
`define SPDRX_ADDR_DECODE   16'hf602

`define SPDRX_CTRL_RESET    4'h0
`define SPDRX_DEC_RESET     10'h000
`define SPDRX_ZERO16        16'h0000

`define SPDRX_CTRL_QSEL     3
`define SPDRX_CTRL_HOLD     2
`define SPDRX_CTRL_WL_HI    1
`define SPDRX_CTRL_WL_LO    0

`define SPDRX_DEC_R_HI      9
`define SPDRX_DEC_R_LO      6
`define SPDRX_DEC_L_HI      5
`define SPDRX_DEC_L_LO      2
`define SPDRX_DEC_FMT       1
`define SPDRX_DEC_COMP      0
`define SPDRX_LOCK_BIT      0

`define SPDRX_RUN_NORMAL    7'h40
`define SPDRX_RUN_FAST      7'h08
`define SPDRX_RUN_ONE       7'h01

`define SPDRX_WLSEL_24      2'h0
`define SPDRX_WLSEL_20      2'h1
`define SPDRX_WLSEL_16      2'h2
`define SPDRX_WLSEL_AUTO    2'h3

`define SPDRX_WL16          4'h2
`define SPDRX_WL17          4'hc
`define SPDRX_WL18          4'h4
`define SPDRX_WL19          4'h8
`define SPDRX_WL20          4'ha
`define SPDRX_WL21          4'hd
`define SPDRX_WL22          4'h5
`define SPDRX_WL23          4'h9
`define SPDRX_WL24          4'hb
`define SPDRX_WL20M24       4'h3

`define SPDRX_LEN16         5'h10
`define SPDRX_LEN17         5'h11
`define SPDRX_LEN18         5'h12
`define SPDRX_LEN19         5'h13
`define SPDRX_LEN20         5'h14
`define SPDRX_LEN21         5'h15
`define SPDRX_LEN22         5'h16
`define SPDRX_LEN23         5'h17
`define SPDRX_LEN24         5'h18

`endif

// ==== spdrx_pkg.sv ====
/*
 Types of the S/PDIF receiver lock and decode block.
 Assumes nothing of its surroundings.
*/
package spdrx_pkg;
    typedef enum logic [1:0] {
        spdrx_search = 2'b00,
        spdrx_locked = 2'b01,
        spdrx_coast  = 2'b10
    } spdrx_state_e;
endpackage : spdrx_pkg

// ==== spdrx_buf2.sv ====
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ns
module spdrx_buf2 #(
    parameter int W = 48
) (
    input  wire logic         ref_clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] mem [2];
    logic         wr_ptr;
    logic         rd_ptr;
    logic [1:0]   count;
    logic         push;
    logic         pop;

    assign in_ready  = (count != 2'h2);
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mem[0] <= '0;
            mem[1] <= '0;
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= ~wr_ptr;
            if (pop)
                rd_ptr <= ~rd_ptr;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            count <= 2'h0;
        else if (push && !pop)
            count <= count + 2'h1;
        else if (pop && !push)
            count <= count - 2'h1;
    end
endmodule : spdrx_buf2

// ==== spdrx_top.sv ====
/*
 S/PDIF receiver lock, control and stream decode logic with its registers.
 Assumes the biphase front end on ref_clk delivers samples, a sample check
 flag, channel status codes and the recovered frame clock, all synchronous.
*/
// Strobed register access is this design's own decision.
// Overview of operation
// - Bit 0 of the lock status register reads 1 when locked, else 0.
// - With quick acquire off, lock follows 64 consecutive valid samples.
// - With quick acquire on, lock follows eight consecutive valid samples.
// - With hold policy 0 the frame clock keeps running after lock loss.
// - With hold policy 1 the frame clock stops at once on lock loss.
// - Word length select 00, 01, 10 give 24, 20 and 16 output bits.
// - Word length select 11 takes the length of both channels from the left length in the channel status.
// - Decode bits 9 to 6 give the right length code for 20-bit streams.
// - The same field uses the 24-bit code set for 24-bit streams.
// - Decode bits 5 to 2 give the left length with the same codes.
// - Decode bit 0 is 0 for linear PCM and 1 for compressed data.
// - Decode bit 1 names the compression format, meaningful if bit 0 is 1.
// - The control register resets to all zeros.
// - The audio output is muted whenever lock is lost.
`timescale 1ns/1ns
`include "spdrx_consts.svh"
module spdrx_top #(
    parameter logic [6:0] RUN_NORMAL = `SPDRX_RUN_NORMAL,
    parameter logic [6:0] RUN_FAST   = `SPDRX_RUN_FAST
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        samp_valid,
    output logic             samp_ready,
    input  wire logic        samp_ok,
    input  wire logic [23:0] samp_left,
    input  wire logic [23:0] samp_right,
    input  wire logic        cs_update,
    input  wire logic [3:0]  cs_len_left,
    input  wire logic [3:0]  cs_len_right,
    input  wire logic        cs_compressed,
    input  wire logic        cs_format,
    input  wire logic        fs_in,
    output logic             fs_out,
    output logic             rx_locked,
    output logic             aud_valid,
    input  wire logic        aud_ready,
    output logic      [23:0] aud_left,
    output logic      [23:0] aud_right
);

    function automatic logic [4:0] spdrx_len_of(input logic [3:0] code);
        logic [4:0] len;
        len = `SPDRX_LEN24;
        unique case (code)
            `SPDRX_WL16:    len = `SPDRX_LEN16;
            `SPDRX_WL17:    len = `SPDRX_LEN17;
            `SPDRX_WL18:    len = `SPDRX_LEN18;
            `SPDRX_WL19:    len = `SPDRX_LEN19;
            `SPDRX_WL20:    len = `SPDRX_LEN20;
            `SPDRX_WL21:    len = `SPDRX_LEN21;
            `SPDRX_WL22:    len = `SPDRX_LEN22;
            `SPDRX_WL23:    len = `SPDRX_LEN23;
            `SPDRX_WL24:    len = `SPDRX_LEN24;
            `SPDRX_WL20M24: len = `SPDRX_LEN20;
            default:        len = `SPDRX_LEN24;
        endcase
        return len;
    endfunction : spdrx_len_of

    // Keeps the top len bits of a 24-bit word, clears the rest
    function automatic logic [23:0] spdrx_trim(input logic [23:0] word,
                                               input logic [4:0]  len);
        logic [23:0] out;
        out = word;
        for (int i = 0; i < 24; i++) begin
            if (5'(i) < (`SPDRX_LEN24 - len))
                out[i] = 1'b0;
        end
        return out;
    endfunction : spdrx_trim

    spdrx_pkg::spdrx_state_e state;
    spdrx_pkg::spdrx_state_e next_state;
    logic [6:0]  run_cnt;
    logic [6:0]  next_run;
    logic [6:0]  run_need;
    logic        quick_acquire_sel;
    logic        clock_out_hold_policy;
    logic [1:0]  word_length_select;
    logic [3:0]  right_len_detected;
    logic [3:0]  left_len_detected;
    logic        compression_format;
    logic        payload_compressed;
    logic        accept;
    logic        run_full;
    logic        locked;
    logic [4:0]  out_len;
    logic [47:0] push_data;
    logic        push_ready;
    logic [47:0] pop_data;
    logic [15:0] next_rdata;

    assign locked     = (state == spdrx_pkg::spdrx_locked);
    assign rx_locked  = locked;
    assign samp_ready = push_ready;
    // A stalled buffer holds the front end, so no word is lost
    assign accept     = samp_valid & push_ready;
    assign aud_left   = pop_data[47:24];
    assign aud_right  = pop_data[23:0];

    assign run_need = quick_acquire_sel ? RUN_FAST : RUN_NORMAL;
    // A shortened target while counting still locks on the next good sample
    assign run_full = (run_cnt >= (run_need - `SPDRX_RUN_ONE));

    always_comb begin
        next_run = run_cnt;
        if (accept) begin
            if (!samp_ok)
                next_run = 7'h00;
            else if (!run_full)
                next_run = run_cnt + `SPDRX_RUN_ONE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            run_cnt <= 7'h00;
        else
            run_cnt <= next_run;
    end

    always_comb begin
        next_state = state;
        unique case (state)
            spdrx_pkg::spdrx_search,
            spdrx_pkg::spdrx_coast: begin
                if (accept && samp_ok && run_full)
                    next_state = spdrx_pkg::spdrx_locked;
            end
            spdrx_pkg::spdrx_locked: begin
                if (accept && !samp_ok)
                    next_state = spdrx_pkg::spdrx_coast;
            end
            default: next_state = spdrx_pkg::spdrx_search;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            state <= spdrx_pkg::spdrx_search;
        else
            state <= next_state;
    end

    // frame clock on lock loss
    // Gated from next_state so a stop takes effect on the losing edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            fs_out <= 1'b0;
        else
            fs_out <= fs_in & ((next_state == spdrx_pkg::spdrx_locked) |
                               ((next_state == spdrx_pkg::spdrx_coast) &
                                !clock_out_hold_policy));
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {quick_acquire_sel, clock_out_hold_policy, word_length_select}
                <= `SPDRX_CTRL_RESET;
        end else if (reg_wr && reg_addr == `SPDRX_ADDR_CTRL) begin
            quick_acquire_sel     <= reg_wdata[`SPDRX_CTRL_QSEL];
            clock_out_hold_policy <= reg_wdata[`SPDRX_CTRL_HOLD];
            word_length_select    <= reg_wdata[`SPDRX_CTRL_WL_HI:`SPDRX_CTRL_WL_LO];
        end
    end

    // decode refresh
    // Writes are ignored; last locked stream values hold after loss
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {right_len_detected, left_len_detected, compression_format,
             payload_compressed} <= `SPDRX_DEC_RESET;
        end else if (locked && cs_update) begin
            right_len_detected <= cs_len_right;
            left_len_detected  <= cs_len_left;
            compression_format <= cs_format;
            payload_compressed <= cs_compressed;
        end
    end

    always_comb begin
        unique case (word_length_select)
            `SPDRX_WLSEL_24:   out_len = `SPDRX_LEN24;
            `SPDRX_WLSEL_20:   out_len = `SPDRX_LEN20;
            `SPDRX_WLSEL_16:   out_len = `SPDRX_LEN16;
            `SPDRX_WLSEL_AUTO: out_len = spdrx_len_of(left_len_detected);
        endcase
    end

    always_comb begin
        if (next_state == spdrx_pkg::spdrx_locked)
            push_data = {spdrx_trim(samp_left, out_len),
                         spdrx_trim(samp_right, out_len)};
        else
            push_data = 48'h0000_0000_0000;
    end

    spdrx_buf2 #(
        .W(48)
    ) u_buf (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (samp_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (aud_valid),
        .out_ready (aud_ready),
        .out_data  (pop_data)
    );

    always_comb begin
        next_rdata = `SPDRX_ZERO16;
        unique case (reg_addr)
            `SPDRX_ADDR_LOCK:   next_rdata[`SPDRX_LOCK_BIT] = locked;
            `SPDRX_ADDR_CTRL: begin
                next_rdata[`SPDRX_CTRL_QSEL] = quick_acquire_sel;
                next_rdata[`SPDRX_CTRL_HOLD] = clock_out_hold_policy;
                next_rdata[`SPDRX_CTRL_WL_HI:`SPDRX_CTRL_WL_LO] = word_length_select;
            end
            `SPDRX_ADDR_DECODE: begin
                next_rdata[`SPDRX_DEC_R_HI:`SPDRX_DEC_R_LO] = right_len_detected;
                next_rdata[`SPDRX_DEC_L_HI:`SPDRX_DEC_L_LO] = left_len_detected;
                next_rdata[`SPDRX_DEC_FMT]  = compression_format;
                next_rdata[`SPDRX_DEC_COMP] = payload_compressed;
            end
            default: next_rdata = `SPDRX_ZERO16;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            reg_rdata <= `SPDRX_ZERO16;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= `SPDRX_ZERO16;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence lock_read_s;
        reg_rd && reg_addr == `SPDRX_ADDR_LOCK;
    endsequence

    sequence cs_take_s;
        locked && cs_update;
    endsequence

    lock_bit_a: assert property (
        lock_read_s |=> reg_rdata[`SPDRX_LOCK_BIT] == $past(locked)
                        && reg_rdata[15:1] == 15'h0000)
        else $error("lock status bit does not match lock state");

    normal_lock_a: assert property (
        $rose(locked) && !$past(quick_acquire_sel)
        |-> $past(run_cnt) == RUN_NORMAL - `SPDRX_RUN_ONE)
        else $error("normal lock taken without 64 good samples");

    fast_lock_a: assert property (
        $rose(locked) && $past(quick_acquire_sel)
        |-> $past(run_cnt) >= RUN_FAST - `SPDRX_RUN_ONE)
        else $error("fast lock taken without eight good samples");

    loss_exit_a: assert property (
        locked && accept && !samp_ok |=> !locked && run_cnt == 7'h00)
        else $error("bad sample did not drop lock");

    coast_clock_a: assert property (
        state == spdrx_pkg::spdrx_coast && !clock_out_hold_policy
        |=> fs_out == $past(fs_in) || state == spdrx_pkg::spdrx_locked)
        else $error("frame clock stopped while coasting");

    stop_clock_a: assert property (
        $fell(locked) && $past(clock_out_hold_policy) |-> !fs_out)
        else $error("frame clock ran on after lock loss");

    len16_trim_a: assert property (
        word_length_select == `SPDRX_WLSEL_16 && accept
        |=> $past(push_data[7:0]) == 8'h00 && $past(push_data[31:24]) == 8'h00)
        else $error("16-bit output keeps low bits");

    auto_len_a: assert property (
        word_length_select == `SPDRX_WLSEL_AUTO
        && left_len_detected == `SPDRX_WL18 |-> out_len == `SPDRX_LEN18)
        else $error("automatic length ignores channel status");

    decode_upd_a: assert property (
        cs_take_s |=> right_len_detected == $past(cs_len_right)
                      && left_len_detected == $past(cs_len_left)
                      && compression_format == $past(cs_format)
                      && payload_compressed == $past(cs_compressed))
        else $error("decode fields not refreshed while locked");

    mute_out_a: assert property (
        accept && !(samp_ok && (locked || run_full)) |-> push_data == 48'h0000_0000_0000)
        else $error("audio not muted while unlocked");

endmodule : spdrx_top

// ==== spdrx_src.sv ====
/*
 Front end stand-in: offers checked samples and a free-running frame clock.
 Assumes one clock; the bench calls send and waits for the take.
*/
`timescale 1ns/1ns
module spdrx_src (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    output logic             samp_valid,
    input  wire logic        samp_ready,
    output logic             samp_ok,
    output logic      [23:0] samp_left,
    output logic      [23:0] samp_right,
    output logic             fs_in
);
    logic [2:0] fs_cnt;

    initial begin
        samp_valid = 1'b0;
        samp_ok    = 1'b0;
        samp_left  = 24'h00_0000;
        samp_right = 24'h00_0000;
    end

    // Frame clock runs free, eight cycles a period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fs_cnt <= 3'h0;
        end else begin
            fs_cnt <= fs_cnt + 3'h1;
        end
    end
    assign fs_in = fs_cnt[2];

    task automatic send(input logic ok, input logic [23:0] l, input logic [23:0] r);
        @(posedge ref_clk);
        samp_valid <= 1'b1;
        samp_ok    <= ok;
        samp_left  <= l;
        samp_right <= r;
        // Held until taken; a full buffer only delays
        do @(posedge ref_clk); while (samp_ready !== 1'b1);
        samp_valid <= 1'b0;
        // Released lines never keep the last value
        samp_ok    <= ~ok;
        samp_left  <= ~l;
        samp_right <= ~r;
    endtask : send
endmodule : spdrx_src

// ==== tb_top.sv ====
/*
 Self-checking bench of the receiver lock and decode block.
 Assumes spdrx_src as front end and a randomly stalling audio sink.
*/
`timescale 1ns/1ns
`include "spdrx_consts.svh"
module tb_top;
    logic        ref_clk;
    logic        rst;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        samp_valid;
    logic        samp_ready;
    logic        samp_ok;
    logic [23:0] samp_left;
    logic [23:0] samp_right;
    logic        cs_update;
    logic [3:0]  cs_len_left;
    logic [3:0]  cs_len_right;
    logic        cs_compressed;
    logic        cs_format;
    logic        fs_in;
    logic        fs_out;
    logic        rx_locked;
    logic        aud_valid;
    logic        aud_ready;
    logic [23:0] aud_left;
    logic [23:0] aud_right;
    int          n_fail;
    int          n_tests;
    int          cyc;
    int          cnt;
    logic        locked;
    logic        rd_seen;
    logic [3:0]  ctl;
    logic [15:0] dec;
    logic [15:0] rd_q[$];
    logic [47:0] aud_q[$];
    logic [47:0] exp_a;
    logic [3:0]  wl_code [10] = '{4'h2, 4'hc, 4'h4, 4'h8, 4'ha, 4'hd, 4'h5, 4'h9, 4'hb, 4'h3};
    int          wl_len [10]  = '{16, 17, 18, 19, 20, 21, 22, 23, 24, 20};

    spdrx_top i_spdrx_top (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .samp_valid(samp_valid), .samp_ready(samp_ready), .samp_ok(samp_ok),
        .samp_left(samp_left), .samp_right(samp_right), .cs_update(cs_update),
        .cs_len_left(cs_len_left), .cs_len_right(cs_len_right),
        .cs_compressed(cs_compressed), .cs_format(cs_format), .fs_in(fs_in),
        .fs_out(fs_out), .rx_locked(rx_locked), .aud_valid(aud_valid),
        .aud_ready(aud_ready), .aud_left(aud_left), .aud_right(aud_right)
    );

    spdrx_src i_spdrx_src (
        .ref_clk(ref_clk), .rst(rst), .samp_valid(samp_valid), .samp_ready(samp_ready),
        .samp_ok(samp_ok), .samp_left(samp_left), .samp_right(samp_right), .fs_in(fs_in)
    );

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic close_out;
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk16

    task automatic chk48(input string what, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk48

    task automatic chk1(input string what, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : chk1

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
        if (a == `SPDRX_ADDR_CTRL) ctl = d[3:0];
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        rd_q.push_back(e);
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
    endtask : rd

    task automatic cs(input logic [3:0] l, input logic [3:0] r, input logic c, input logic f);
        @(posedge ref_clk);
        cs_len_left   <= l;
        cs_len_right  <= r;
        cs_compressed <= c;
        cs_format     <= f;
        cs_update     <= 1'b1;
        @(posedge ref_clk);
        cs_update     <= 1'b0;
        if (locked) dec = {6'h00, r, l, f, c};
    endtask : cs

    // Notes the trimmed or muted words, then offers the sample
    task automatic smp(input logic ok);
        logic [23:0] l;
        logic [23:0] r;
        logic [23:0] m;
        int          n;
        l = 24'($urandom);
        r = 24'($urandom);
        n = (ctl[1:0] == 2'h0) ? 24 : (ctl[1:0] == 2'h1) ? 20 : (ctl[1:0] == 2'h2) ? 16 : 24;
        for (int i = 0; i < 10; i++) begin
            if (ctl[1:0] == 2'h3 && wl_code[i] == dec[5:2]) n = wl_len[i];
        end
        m = 24'hff_ffff << (24 - n);
        if (ok && !locked) begin
            cnt++;
            locked = (cnt >= (ctl[3] ? 8 : 64));
        end else if (!ok) begin
            cnt = 0;
            locked = 1'b0;
        end
        if (!locked) m = 24'h00_0000;
        aud_q.push_back({l & m, r & m});
        i_spdrx_src.send(ok, l, r);
    endtask : smp

    task automatic fs_chk(input logic stop);
        logic prv;
        repeat (2) @(posedge ref_clk);
        prv = fs_in;
        repeat (8) begin
            @(posedge ref_clk);
            chk1("fs_out", stop ? 1'b0 : prv, fs_out);
            prv = fs_in;
        end
    endtask : fs_chk

    always @(posedge ref_clk) begin
        if (rd_seen === 1'b1) begin
            chk16("reg_rdata", rd_q.pop_front(), reg_rdata);
        end
        rd_seen <= reg_rd;
        if (aud_valid === 1'b1 && aud_ready === 1'b1) begin
            exp_a = (aud_q.size() > 0) ? aud_q.pop_front() : {48{1'bx}};
            chk48("aud_words", exp_a, {aud_left, aud_right});
        end
        // Sink stalls one cycle in four so the buffer fills
        aud_ready <= ($urandom % 4) != 0;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            close_out();
        end
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        cyc = 0;
        cnt = 0;
        locked = 1'b0;
        rd_seen = 1'b0;
        ctl = 4'h0;
        dec = 16'h0000;
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cs_update = 1'b0;
        cs_len_left = 4'h0;
        cs_len_right = 4'h0;
        cs_compressed = 1'b0;
        cs_format = 1'b0;
        aud_ready = 1'b0;
        void'($urandom(6));
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(`SPDRX_ADDR_LOCK, 16'h0000);
        rd(`SPDRX_ADDR_CTRL, 16'h0000);
        rd(`SPDRX_ADDR_DECODE, 16'h0000);
        rd(16'hf603, 16'h0000);
        wr(`SPDRX_ADDR_LOCK, 16'hffff);
        wr(`SPDRX_ADDR_DECODE, 16'hffff);
        rd(`SPDRX_ADDR_LOCK, 16'h0000);
        rd(`SPDRX_ADDR_DECODE, 16'h0000);
        wr(`SPDRX_ADDR_CTRL, 16'hfff0);
        rd(`SPDRX_ADDR_CTRL, 16'h0000);
        wr(`SPDRX_ADDR_CTRL, 16'h0000);
        repeat (63) smp(1'b1);
        rd(`SPDRX_ADDR_LOCK, 16'h0000);
        smp(1'b1);
        rd(`SPDRX_ADDR_LOCK, 16'h0001);
        chk1("rx_locked", 1'b1, rx_locked);
        for (int s = 0; s < 3; s++) begin
            wr(`SPDRX_ADDR_CTRL, 16'(s));
            rd(`SPDRX_ADDR_CTRL, 16'(s));
            smp(1'b1);
        end
        for (int i = 0; i < 10; i++) begin
            cs(wl_code[i], wl_code[9 - i], i[0], i[1]);
            rd(`SPDRX_ADDR_DECODE, dec);
        end
        wr(`SPDRX_ADDR_CTRL, 16'h0003);
        smp(1'b1);
        cs(4'hc, 4'hb, 1'b0, 1'b0);
        smp(1'b1);
        cs(4'h4, 4'h2, 1'b1, 1'b0);
        rd(`SPDRX_ADDR_DECODE, dec);
        smp(1'b1);
        wr(`SPDRX_ADDR_CTRL, 16'h0000);
        smp(1'b0);
        rd(`SPDRX_ADDR_LOCK, 16'h0000);
        fs_chk(1'b0);
        cs(4'h5, 4'h5, 1'b1, 1'b1);
        rd(`SPDRX_ADDR_DECODE, dec);
        wr(`SPDRX_ADDR_CTRL, 16'h000c);
        repeat (7) smp(1'b1);
        rd(`SPDRX_ADDR_LOCK, 16'h0000);
        smp(1'b1);
        rd(`SPDRX_ADDR_LOCK, 16'h0001);
        smp(1'b0);
        fs_chk(1'b1);
        for (int k = 0; k < 200 && aud_q.size() > 0; k++) begin
            @(posedge ref_clk);
        end
        repeat (3) @(posedge ref_clk);
        if (aud_q.size() > 0) n_fail++;
        close_out();
    end
endmodule : tb_top
